// >>> include/ust_pkg.sv
package ust_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_IER = 4'h1;
	localparam logic [3:0] OFS_MCR = 4'h4;
	localparam logic [3:0] OFS_LSR = 4'h5;
	localparam logic [3:0] OFS_MSR = 4'h6;
	localparam logic [3:0] OFS_SPR = 4'h7;
	localparam logic [3:0] OFS_FEATURE_CONTROL = 4'h8;
	localparam logic [3:0] OFS_EFR = 4'h9;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] SPR_RST = 8'hff;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] DLY_RST = 4'h0;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int IER_RX = 0;
	localparam int IER_THR = 1;
	localparam int IER_LSR = 2;
	localparam int IER_MSR = 3;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_AFSEL = 2;
	localparam int MCR_OP2 = 3;
	localparam int MCR_LOOP = 4;
	localparam int EFR_ENH = 4;
	localparam int EFR_ACTS = 7;
	localparam int FEATURE_CONTROL_IRINV = 4;
	localparam int FEATURE_CONTROL_485 = 5;
	localparam logic [1:0] TABLE_D = 2'h3;

	// ----------------------------------------
	// Sizes and tables
	// ----------------------------------------
	localparam int FIFO_DEPTH = 64;
	localparam logic [5:0] HYST_LUT [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
		6'h0c, 6'h14, 6'h1c, 6'h24, 6'h28, 6'h2c, 6'h30, 6'h34};

	typedef struct packed {
		logic brk;
		logic fe;
		logic pe;
		logic [7:0] data;
	} ust_rx_char_s;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_DRIVE = 2'b01,
		RS_TURN = 2'b10
	} ust_rs_e;

endpackage

// >>> test/ust_line_model.sv
`timescale 1ns/1ns
module ust_line_model
	import ust_pkg::*;
#(
	parameter int DIV = 4
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_take,
	output logic tx_busy,
	output logic bit_tick,
	output logic [7:0] last_byte
);
	int div_q;
	int bits_q;
	// Only takes between characters, so a halt lands on a character boundary
	assign tx_take = tx_valid && !tx_busy;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= 0;
			bit_tick <= 1'b0;
		end else begin
			div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
			bit_tick <= div_q == DIV - 1;
		end
	end
	// Ten bit times per frame; busy covers the stop bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_busy <= 1'b0;
			bits_q <= 0;
			last_byte <= 8'h00;
		end else if (tx_take) begin
			tx_busy <= 1'b1;
			bits_q <= 10;
			last_byte <= tx_data;
		end else if (tx_busy && bit_tick) begin
			bits_q <= bits_q - 1;
			tx_busy <= bits_q != 1;
		end
	end
endmodule

// >>> test/ust_status_ctrl_checker.sv
`timescale 1ns/1ns
module ust_status_ctrl_checker
	import ust_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic rx_done,
	input wire logic tx_valid,
	input wire logic tx_take,
	input wire logic ir_rx_in,
	input wire logic ir_rx_dec,
	input wire logic [1:0] trig_table,
	input wire logic hyst_on,
	input wire logic [5:0] hyst_chars
);
	// ----------------------------------------
	// Shadow registers
	// ----------------------------------------
	logic [7:0] spr_q;
	logic [7:0] feature_control_q;
	logic lsr_rd;
	assign lsr_rd = reg_rd && reg_addr == OFS_LSR;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			spr_q <= SPR_RST;
		end else if (reg_wr && reg_addr == OFS_SPR) begin
			spr_q <= reg_wdata;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			feature_control_q <= REG_RST;
		end else if (reg_wr && reg_addr == OFS_FEATURE_CONTROL) begin
			feature_control_q <= reg_wdata;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	a_scratch_keeps: assert property (reg_rd && reg_addr == OFS_SPR |=> reg_rdata == $past(spr_q))
		else $error("scratch read mismatch");
	a_lsr_clears: assert property ((lsr_rd && !rx_done) ##1 (!rx_done && !reg_rd) ##1 (lsr_rd && !rx_done)
		|=> reg_rdata[4:1] == 4'h0)
		else $error("line status error bits not cleared by read");
	a_unmapped_zero: assert property (reg_rd && (reg_addr inside {4'h2, 4'h3} || reg_addr > 4'h9)
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_table_pick: assert property (trig_table == feature_control_q[7:6])
		else $error("trigger table mismatch");
	a_hyst_gated: assert property (hyst_on == (feature_control_q[7:6] == TABLE_D))
		else $error("hysteresis enable mismatch");
	a_hyst_count: assert property (hyst_chars == (hyst_on ? HYST_LUT[feature_control_q[3:0]] : 6'h00))
		else $error("hysteresis count mismatch");
	a_ir_polarity: assert property (ir_rx_dec == (ir_rx_in ^ feature_control_q[FEATURE_CONTROL_IRINV]))
		else $error("infrared polarity mismatch");
	c_lsr_read: cover property (lsr_rd ##[1:3] lsr_rd);
	c_tx_take: cover property (tx_valid && tx_take);
	c_table_d: cover property (hyst_on && hyst_chars != 6'h00);
endmodule
bind ust_status_ctrl ust_status_ctrl_checker chk_u(.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .rx_done, .tx_valid, .tx_take, .ir_rx_in, .ir_rx_dec, .trig_table, .hyst_on, .hyst_chars);

// >>> test/ust_status_ctrl_tb.sv
`timescale 1ns/1ns
module ust_status_ctrl_tb
	import ust_pkg::*;
;
	typedef struct {logic w; logic [3:0] a; logic [7:0] d;} ust_row_s;
	logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, fifo_en = 0, rx_done = 0, ir_rx_in = 0;
	logic cts_n = 1, dsr_n = 1, ri_n = 1, cd_n = 1, tx_valid, tx_take, tx_busy, bit_tick;
	logic rts_n, dtr_n, irq, ir_rx_dec, hyst_on;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, tx_data, last_byte;
	logic [1:0] trig_table;
	logic [5:0] hyst_chars;
	ust_rx_char_s rx_char = '0;
	int n_mismatch = 0, num_checks = 0, cyc = 0, n;
	ust_row_s rows [12] = '{'{0, OFS_SPR, 8'hff}, '{1, OFS_SPR, 8'ha5}, '{0, OFS_SPR, 8'ha5},
		'{0, 4'h2, 8'h00}, '{1, 4'h2, 8'h77}, '{0, 4'h2, 8'h00}, '{1, OFS_FEATURE_CONTROL, 8'hd7}, '{0, OFS_FEATURE_CONTROL, 8'hd7},
		'{0, OFS_LSR, 8'h60}, '{1, OFS_FEATURE_CONTROL, 8'h10}, '{0, OFS_FEATURE_CONTROL, 8'h10}, '{0, OFS_MSR, 8'h00}};
	always #25 clk = ~clk;
	ust_status_ctrl dut(.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .fifo_en, .rx_done,
		.rx_char, .tx_data, .tx_valid, .tx_take, .tx_busy, .bit_tick, .cts_n, .dsr_n, .ri_n, .cd_n, .rts_n,
		.dtr_n, .irq, .ir_rx_in, .ir_rx_dec, .trig_table, .hyst_on, .hyst_chars);
	ust_line_model line_u(.clk, .arst_n, .tx_valid, .tx_data, .tx_take, .tx_busy, .bit_tick, .last_byte);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		@(negedge clk);
		chk("reg_rdata", e, reg_rdata & m);
	endtask
	task rx(input logic [10:0] c);
		@(posedge clk);
		rx_char <= c;
		rx_done <= 1;
		@(posedge clk);
		rx_done <= 0;
	endtask
	// Bounded wait for the transmitter to reach a busy level
	task wt(input logic v);
		n = 0;
		while (tx_busy !== v && n < 500) begin
			@(negedge clk);
			n++;
		end
		chk("tx_busy", v, tx_busy);
	endtask
	task results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1;
		ir_rx_in <= 1;
		@(negedge clk);
		chk("reset pins", 8'h0c, {4'h0, rts_n, dtr_n, irq, tx_valid});
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rd(rows[i].a, rows[i].d);
		end
		wr(OFS_IER, 8'h04);
		rx(11'h303);
		@(negedge clk);
		chk("irq", 1, irq);
		rd(OFS_LSR, 8'hed);
		rd(OFS_LSR, 8'he1);
		rd(OFS_DATA, 8'h03);
		rd(OFS_LSR, 8'h60);
		chk("irq", 0, irq);
		@(posedge clk);
		fifo_en <= 1;
		rx(11'h400);
		rx(11'h400);
		rd(OFS_LSR, 8'hf1);
		rd(OFS_DATA, 8'h00);
		rd(OFS_LSR, 8'h60);
		for (int i = 0; i < 65; i++) rx(11'(i));
		rd(OFS_LSR, 8'h63);
		for (int i = 0; i < 64; i++) rd(OFS_DATA, 8'(i));
		rd(OFS_LSR, 8'h60);
		wr(OFS_IER, 8'h08);
		@(posedge clk);
		cts_n <= 0;
		repeat (3) @(negedge clk);
		chk("irq", 1, irq);
		rd(OFS_MSR, 8'h11);
		rd(OFS_MSR, 8'h10);
		@(posedge clk);
		ri_n <= 0;
		rd(OFS_MSR, 8'h50);
		@(posedge clk);
		ri_n <= 1;
		rd(OFS_MSR, 8'h14);
		@(posedge clk);
		dsr_n <= 0;
		cd_n <= 0;
		rd(OFS_MSR, 8'hba);
		@(posedge clk);
		cts_n <= 1;
		dsr_n <= 1;
		cd_n <= 1;
		wr(OFS_MCR, 8'h1f);
		@(negedge clk);
		chk("dtr_n", 0, dtr_n);
		rd(OFS_MSR, 8'hf0, 8'hf0);
		wr(OFS_MCR, 8'h10);
		rd(OFS_MSR, 8'h00, 8'hf0);
		wr(OFS_MCR, 8'h00);
		rd(OFS_MSR, 8'h00, 8'hf0);
		wr(OFS_EFR, 8'h90);
		wr(OFS_DATA, 8'h55);
		repeat (20) @(negedge clk);
		chk("tx_valid", 0, tx_valid);
		@(posedge clk);
		cts_n <= 0;
		wt(1);
		chk("tx byte", 8'h55, last_byte);
		wt(0);
		wr(OFS_EFR, 8'h10);
		wr(OFS_MSR, 8'h30);
		wr(OFS_FEATURE_CONTROL, 8'h20);
		wr(OFS_IER, 8'h02);
		repeat (30) @(negedge clk);
		chk("rts_n", 0, rts_n);
		wr(OFS_DATA, 8'h41);
		@(negedge clk);
		chk("rts_n", 1, rts_n);
		wt(1);
		chk("irq", 0, irq);
		wt(0);
		n = 0;
		while (rts_n !== 0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk("turnaround", 1, n >= 9 && n <= 15);
		chk("irq", 1, irq);
		// Table C: hysteresis must stay off whatever the low nibble says
		wr(OFS_FEATURE_CONTROL, 8'h85);
		@(negedge clk);
		chk("hyst_chars", 8'h00, {2'h0, hyst_chars});
		chk("irq", 1, irq);
		wr(OFS_FEATURE_CONTROL, 8'hc5);
		@(negedge clk);
		chk("hyst_on", 1, hyst_on);
		chk("trig_table", 8'h03, {6'h00, trig_table});
		chk("hyst_chars", 8'h10, {2'h0, hyst_chars});
		chk("ir_rx_dec", 1, ir_rx_dec);
		results();
	end
endmodule

// >>> verilog/ust_status_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// RULE1: line-status interrupt on any errored FIFO character
// RULE2: reading line status clears bits four..one
// RULE3: data ready while receive data waits
// RULE4: overrun on full FIFO, FIFO untouched
// RULE5: parity flag tracks readable character only
// RULE6: framing flag tracks readable character only
// RULE7: one break character per break event
// RULE8: holding empty sets on empty, clears on write
// RULE9: holding empty with enable raises interrupt
// RULE10: transmitter empty only when fully idle
// RULE11: bit seven while errored characters remain
// RULE12: CTS DSR CD deltas, modem interrupt
// RULE13: ring delta only on ring ending edge
// RULE14: auto CTS halts between characters
// RULE15: status upper nibble is inverted pins
// RULE16: loopback mirrors modem control bits
// RULE17: turnaround delay 0..15 bit times
// RULE18: delay writes only with enhanced enable
// RULE19: scratch register, resets to all ones
// RULE20: hysteresis used only with table D
// RULE21: infrared receive polarity select
// RULE22: RTS low after last stop plus delay
// RULE23: RTS high on load before start bit
// RULE24: RS485 moves transmit interrupt to shift empty
// RULE25: hysteresis encoding to character counts
// RULE26: bits seven..six pick trigger table
// RULE27: modem status read clears deltas
// RULE28: delay counts transmitter bit periods
module ust_status_ctrl
	import ust_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic fifo_en,
	input wire logic rx_done,
	input wire ust_rx_char_s rx_char,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_take,
	input wire logic tx_busy,
	input wire logic bit_tick,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	output logic rts_n,
	output logic dtr_n,
	output logic irq,
	input wire logic ir_rx_in,
	output logic ir_rx_dec,
	output logic [1:0] trig_table,
	output logic hyst_on,
	output logic [5:0] hyst_chars
);

	// ----------------------------------------
	// Register port decode
	// ----------------------------------------
	logic wr_thr, wr_ier, wr_mcr, wr_dly, wr_spr, wr_feature_control, wr_efr;
	logic rd_rhr, rd_lsr, rd_msr;
	assign wr_thr = reg_wr && reg_addr == OFS_DATA;
	assign wr_ier = reg_wr && reg_addr == OFS_IER;
	assign wr_mcr = reg_wr && reg_addr == OFS_MCR;
	assign wr_dly = reg_wr && reg_addr == OFS_MSR;
	assign wr_spr = reg_wr && reg_addr == OFS_SPR;
	assign wr_feature_control = reg_wr && reg_addr == OFS_FEATURE_CONTROL;
	assign wr_efr = reg_wr && reg_addr == OFS_EFR;
	assign rd_rhr = reg_rd && reg_addr == OFS_DATA;
	assign rd_lsr = reg_rd && reg_addr == OFS_LSR;
	assign rd_msr = reg_rd && reg_addr == OFS_MSR;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [3:0] interrupt_enable;
	logic [7:0] modem_control, enhanced_feature, feature_control, scratch_pad;
	logic [3:0] dly;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			interrupt_enable <= REG_RST[3:0];
			enhanced_feature <= REG_RST;
			feature_control <= REG_RST;
		end else begin
			if (wr_ier)
				interrupt_enable <= reg_wdata[3:0];
			if (wr_efr)
				enhanced_feature <= reg_wdata;
			if (wr_feature_control)
				feature_control <= reg_wdata;
		end
	end

	// Upper modem control bits are latched unless enhanced mode is open
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			modem_control <= REG_RST;
		else if (wr_mcr)
			modem_control <= enhanced_feature[EFR_ENH] ? reg_wdata : {modem_control[7:5], reg_wdata[4:0]};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			dly <= DLY_RST;
		else if (wr_dly && enhanced_feature[EFR_ENH])
			dly <= reg_wdata[7:4]; // [RULE17] [RULE18]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			scratch_pad <= SPR_RST; // [RULE19]
		else if (wr_spr)
			scratch_pad <= reg_wdata; // [RULE19]
	end

	// ----------------------------------------
	// Receive FIFO
	// ----------------------------------------
	ust_rx_char_s rx_mem [FIFO_DEPTH];
	ust_rx_char_s head;
	logic [5:0] rx_wp, rx_rp;
	logic [6:0] rx_cnt, err_cnt;
	logic rx_full, rx_push, rx_pop, brk_held, brk_dup, dr;
	logic push_err, pop_err, ovr, hide, show;

	assign head = rx_mem[rx_rp];
	assign dr = rx_cnt != 7'h00; // [RULE3]
	// Without the FIFO the holding register is a one-deep FIFO
	assign rx_full = fifo_en ? rx_cnt == 7'(FIFO_DEPTH) : dr;
	assign brk_dup = rx_char.brk && brk_held; // [RULE7]
	assign rx_push = rx_done && !rx_full && !brk_dup; // [RULE4]
	assign rx_pop = rd_rhr && dr;
	assign push_err = rx_push && (rx_char.pe || rx_char.fe || rx_char.brk);
	assign pop_err = rx_pop && (head.pe || head.fe || head.brk);

	always_ff @(posedge clk) begin
		if (rx_push)
			rx_mem[rx_wp] <= rx_char;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_wp <= 6'h00;
			rx_rp <= 6'h00;
			rx_cnt <= 7'h00;
		end else begin
			if (rx_push)
				rx_wp <= rx_wp + 6'h01;
			if (rx_pop)
				rx_rp <= rx_rp + 6'h01;
			if (rx_push && !rx_pop)
				rx_cnt <= rx_cnt + 7'h01;
			else if (rx_pop && !rx_push)
				rx_cnt <= rx_cnt - 7'h01;
		end
	end

	// Count of errored characters still inside the FIFO
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			err_cnt <= 7'h00;
		else if (push_err && !pop_err)
			err_cnt <= err_cnt + 7'h01; // [RULE11]
		else if (pop_err && !push_err)
			err_cnt <= err_cnt - 7'h01; // [RULE11]
	end

	// A break held across several frames yields one character only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			brk_held <= 1'b0;
		else if (rx_done)
			brk_held <= rx_char.brk; // [RULE7]
	end

	// Overrun: the set wins over a read in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ovr <= 1'b0;
		else if (rx_done && rx_full)
			ovr <= 1'b1; // [RULE4]
		else if (rd_lsr)
			ovr <= 1'b0; // [RULE2]
	end

	// Error tags follow the head character; a new head shows its own tags again
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hide <= 1'b0;
		else if (rx_pop || (rx_push && !dr))
			hide <= 1'b0; // [RULE5] [RULE6]
		else if (rd_lsr)
			hide <= 1'b1; // [RULE2]
	end
	assign show = dr && !hide;

	// ----------------------------------------
	// Transmit FIFO
	// ----------------------------------------
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [5:0] tx_wp, tx_rp;
	logic [6:0] tx_cnt;
	logic tx_full, tx_push, tx_pop, thre, temt, cts_halt;

	assign tx_full = fifo_en ? tx_cnt == 7'(FIFO_DEPTH) : !thre;
	assign tx_push = wr_thr && !tx_full;
	assign thre = tx_cnt == 7'h00; // [RULE8]
	assign temt = thre && !tx_busy; // [RULE10]
	// The transmitter only takes a byte between characters, so a halt never cuts one short
	assign tx_valid = !thre && !cts_halt; // [RULE14]
	assign tx_pop = tx_take && tx_valid;
	assign tx_data = tx_mem[tx_rp];

	always_ff @(posedge clk) begin
		if (tx_push)
			tx_mem[tx_wp] <= reg_wdata;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_wp <= 6'h00;
			tx_rp <= 6'h00;
			tx_cnt <= 7'h00;
		end else begin
			if (tx_push)
				tx_wp <= tx_wp + 6'h01;
			if (tx_pop)
				tx_rp <= tx_rp + 6'h01;
			if (tx_push && !tx_pop)
				tx_cnt <= tx_cnt + 7'h01; // [RULE8]
			else if (tx_pop && !tx_push)
				tx_cnt <= tx_cnt - 7'h01; // [RULE8]
		end
	end

	// ----------------------------------------
	// Modem status
	// ----------------------------------------
	logic [3:0] lvl, lvl_q, delta, dset;
	logic lvl_ok;

	always_comb begin
		if (modem_control[MCR_LOOP])
			lvl = {modem_control[MCR_OP2], modem_control[MCR_AFSEL], modem_control[MCR_DTR], modem_control[MCR_RTS]}; // [RULE16]
		else
			lvl = ~{cd_n, ri_n, dsr_n, cts_n}; // [RULE15]
	end

	// Ring status falling means the pin went back high: end of ringing
	assign dset = {lvl[3] ^ lvl_q[3], lvl_q[2] && !lvl[2], lvl[1:0] ^ lvl_q[1:0]}; // [RULE12] [RULE13]

	// No delta on the first sample after reset, when the history is unknown
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl_q <= 4'h0;
			lvl_ok <= 1'b0;
		end else begin
			lvl_q <= lvl;
			lvl_ok <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			delta <= 4'h0;
		else
			delta <= (rd_msr ? 4'h0 : delta) | (lvl_ok ? dset : 4'h0); // [RULE27] [RULE12]
	end

	assign cts_halt = enhanced_feature[EFR_ACTS] && !modem_control[MCR_AFSEL] && !lvl[0]; // [RULE14]
	assign dtr_n = !modem_control[MCR_DTR];

	// ----------------------------------------
	// Auto RS485 direction
	// ----------------------------------------
	ust_rs_e rs_st;
	logic [3:0] rs_cnt;
	logic rs_on;
	assign rs_on = feature_control[FEATURE_CONTROL_485];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs_st <= RS_IDLE;
			rs_cnt <= 4'h0;
		end else if (!rs_on) begin
			rs_st <= RS_IDLE;
			rs_cnt <= 4'h0;
		end else begin
			unique case (rs_st)
				RS_IDLE: begin
					if (tx_push || !temt)
						rs_st <= RS_DRIVE; // [RULE23]
				end
				RS_DRIVE: begin
					rs_cnt <= 4'h0;
					if (temt && !tx_push)
						rs_st <= (dly == 4'h0) ? RS_IDLE : RS_TURN; // [RULE22]
				end
				RS_TURN: begin
					if (tx_push || !temt)
						rs_st <= RS_DRIVE; // [RULE23]
					else if (bit_tick) begin
						rs_cnt <= rs_cnt + 4'h1; // [RULE28]
						if (rs_cnt + 4'h1 == dly)
							rs_st <= RS_IDLE; // [RULE17] [RULE22]
					end
				end
				default: rs_st <= RS_IDLE;
			endcase
		end
	end

	// High while the transceiver drives the line
	assign rts_n = rs_on ? (rs_st != RS_IDLE) : !modem_control[MCR_RTS]; // [RULE22] [RULE23]

	// ----------------------------------------
	// Feature control outputs
	// ----------------------------------------
	assign ir_rx_dec = ir_rx_in ^ feature_control[FEATURE_CONTROL_IRINV]; // [RULE21]
	assign trig_table = feature_control[7:6]; // [RULE26]
	assign hyst_on = feature_control[7:6] == TABLE_D; // [RULE20]
	assign hyst_chars = hyst_on ? HYST_LUT[feature_control[3:0]] : 6'h00; // [RULE20] [RULE25]

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	logic tx_src, line_err;
	assign tx_src = rs_on ? temt : thre; // [RULE24]
	assign line_err = ovr || err_cnt != 7'h00 || (show && (head.pe || head.fe || head.brk));
	assign irq = (interrupt_enable[IER_RX] && dr)
		|| (interrupt_enable[IER_THR] && tx_src) // [RULE9]
		|| (interrupt_enable[IER_LSR] && line_err) // [RULE1]
		|| (interrupt_enable[IER_MSR] && delta != 4'h0); // [RULE12]

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] line_status, rd_val;
	assign line_status = {err_cnt != 7'h00, temt, thre, show && head.brk, show && head.fe, show && head.pe, ovr, dr};

	always_comb begin
		unique case (reg_addr)
			OFS_DATA: rd_val = head.data;
			OFS_IER: rd_val = {4'h0, interrupt_enable};
			OFS_MCR: rd_val = modem_control;
			OFS_LSR: rd_val = line_status;
			OFS_MSR: rd_val = {lvl, delta};
			OFS_SPR: rd_val = scratch_pad;
			OFS_FEATURE_CONTROL: rd_val = feature_control;
			OFS_EFR: rd_val = enhanced_feature;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_val;
	end

endmodule
